// *** dcr_far_model.sv ***
// far-side model: peripheral sources and the process id controller
// assumes the bench sets wanted levels just after a rising edge of clk
`timescale 1ns/1ps
`default_nettype none

module dcr_far_model #(
  parameter int NUM_SRC = 69                 // sources 0..68
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic [NUM_SRC-1:0] want_src,  // levels the bench asks for
  input  wire logic [1:0]         want_blk,  // block flags asked for
  output var  logic [NUM_SRC-1:0] src_q,     // source levels to router
  output var  logic               blk0_q,    // first core nmi block
  output var  logic               blk1_q     // second core nmi block
);
  // ----------------------------------------------------------------
  // sources and block flags launch from clk, so they never glitch
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_q  <= '0;
      blk0_q <= 1'b0;
      blk1_q <= 1'b0;
    end else begin
      src_q  <= want_src;     // one level per numbered source
      blk0_q <= want_blk[0];  // held as a level until dropped
      blk1_q <= want_blk[1];
    end
  end
endmodule

`default_nettype wire

// *** dcr_pkg.sv ***
// dual core interrupt router: shared constants
// assumes one system clock; register offsets are byte addresses on a 32-bit AXI4-Lite bus
package dcr_pkg;

  // ----------------------------------------------------------------
  // line classes per core
  // ----------------------------------------------------------------
  localparam int          DCR_NUM_LINES   = 32;            // lines per core
  localparam int          DCR_NUM_PERIPH  = 26;            // of which routable
  localparam logic [31:0] DCR_ROUTABLE    = 32'hDFFE_773F; // 0-5,8-10,12-14,17-28,30-31
  localparam logic [31:0] DCR_EDGE_LINES  = 32'h5040_0400; // 10,22,28,30
  localparam int          DCR_NMI_LINE    = 14;            // non-maskable line
  localparam logic [2:0]  DCR_NMI_LEVEL   = 3'h7;          // level code shown for nmi

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] DCR_ROUTE0_BASE = 12'h000;       // first core, 4 bytes per source
  localparam logic [11:0] DCR_ROUTE1_BASE = 12'h200;       // second core, 4 bytes per source
  localparam logic [11:0] DCR_STATE0_BASE = 12'h400;       // first core source state words
  localparam logic [11:0] DCR_STATE1_BASE = 12'h410;       // second core source state words
  localparam logic [11:0] DCR_EVT_OFS     = 12'h420;       // sticky events, read clears
  localparam logic [11:0] DCR_MASK_OFS    = 12'h424;       // event mask
  localparam logic [11:0] DCR_LVL0_OFS    = 12'h428;       // first core top pending level
  localparam logic [11:0] DCR_LVL1_OFS    = 12'h42C;       // second core top pending level

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int          DCR_ROUTE_W     = 5;             // line number width
  localparam logic [4:0]  DCR_ROUTE_RST   = 5'h10;         // internal line: disconnected
  localparam int          DCR_EVT_W       = 4;             // event bits
  localparam int          DCR_EVT_NMI0    = 0;             // nmi request held by block, core 0
  localparam int          DCR_EVT_NMI1    = 1;             // same, core 1
  localparam int          DCR_EVT_DROP0   = 2;             // active source parked, core 0
  localparam int          DCR_EVT_DROP1   = 3;             // same, core 1
  localparam logic [3:0]  DCR_MASK_RST    = 4'h0;          // all events masked
  localparam logic [1:0]  DCR_RESP_OKAY   = 2'h0;          // axi okay
  localparam logic [1:0]  DCR_RESP_SLVERR = 2'h2;          // axi slave error

endpackage

// *** dcr_router.sv ***
// dual core interrupt router with AXI4-Lite register slave
// assumes sources and nmi block inputs come from logic on clk, so no synchronisers
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// [R1] each core gets 32 lines, 26 routable
// [R2] drive only routable line numbers
// [R3] internal lines never driven by sources
// [R4] edge lines pulse; line 14 is nmi
// [R5] fixed priority level per line
// [R6] independent route register per source per core
// [R7] sources numbered 0 to 68
// [R8] routable value connects source to line
// [R9] any internal value disconnects source
// [R10] shared line is OR of sources
// [R11] nmi block input gates core nmi line
// [R12] live source state readable, read harmless
// [R13] state bit at word s/32, bit s%32
// [R14] route field 5 bits, no error
// [R15] source reaches line within one cycle
module dcr_router
  import dcr_pkg::*;
#(
  parameter int NUM_SRC = 69,                         // sources 0..68
  parameter int ADDR_W  = 12                          // byte address width
) (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic [NUM_SRC-1:0]   src_in,
  input  wire logic                 first_core_nmi_block,
  input  wire logic                 second_core_nmi_block,
  output var  logic [31:0]          first_core_line_q,
  output var  logic [31:0]          second_core_line_q,
  output var  logic                 irq_q,
  input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output var  logic                 s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output var  logic                 s_axi_wready,
  output var  logic [1:0]           s_axi_bresp,
  output var  logic                 s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output var  logic                 s_axi_arready,
  output var  logic [31:0]          s_axi_rdata,
  output var  logic [1:0]           s_axi_rresp,
  output var  logic                 s_axi_rvalid,
  input  wire logic                 s_axi_rready
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // or every active source onto the line its route names [R10]
  function automatic logic [31:0] gather(input logic [NUM_SRC-1:0][4:0] rt,
                                         input logic [NUM_SRC-1:0]      s);
    logic [31:0] v;
    v = 32'h0000_0000;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (s[i]) begin
        v[rt[i]] = 1'b1;                              // [R8]
      end
    end
    return v;
  endfunction

  // priority level of each line [R5]
  function automatic logic [2:0] line_level(input int l);
    case (l)
      0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 12, 13, 17, 18: line_level = 3'h1;
      19, 20, 21:                      line_level = 3'h2;
      11, 15, 22, 23, 27, 29:          line_level = 3'h3;
      24, 25, 28, 30:                  line_level = 3'h4;
      16, 26, 31:                      line_level = 3'h5;
      DCR_NMI_LINE:                    line_level = DCR_NMI_LEVEL; // [R4]
      default:                         line_level = 3'h0;
    endcase
  endfunction

  // highest level among asserted lines
  function automatic logic [2:0] top_level(input logic [31:0] lines);
    logic [2:0] m;
    m = 3'h0;
    for (int l = 0; l < DCR_NUM_LINES; l++) begin
      if (lines[l] && line_level(l) > m) begin
        m = line_level(l);
      end
    end
    return m;
  endfunction

  // address falls on a route register of an existing source [R7]
  function automatic logic route_hit(input logic [ADDR_W-1:0] a);
    return (a[ADDR_W-1:10] == '0) && (int'(a[8:2]) < NUM_SRC) && (a[1:0] == 2'h0);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [1:0][NUM_SRC-1:0][4:0] route_q;              // per core route fields [R6] [R14]
  logic [1:0][31:0]             raw_prev_q;           // last raw line level, for edges
  logic [DCR_EVT_W-1:0]         evt_q;                // sticky events
  logic [DCR_EVT_W-1:0]         mask_q;               // event mask
  logic                         aw_held_q;            // write address waiting
  logic                         w_held_q;             // write data waiting
  logic [ADDR_W-1:0]            aw_addr_q;
  logic [31:0]                  w_data_q;
  logic [3:0]                   w_strb_q;

  // ----------------------------------------------------------------
  // routing matrix
  // ----------------------------------------------------------------
  logic [1:0][31:0] all_lines;                        // every line an active source names
  logic [1:0][31:0] raw_lines;                        // routable lines after nmi gate
  logic [1:0][31:0] line_d;                           // what the cores see next cycle
  logic [1:0]       nmi_blk;
  logic [1:0]       nmi_hit;
  logic [1:0]       dropped;

  assign nmi_blk = {second_core_nmi_block, first_core_nmi_block};

  for (genvar c = 0; c < 2; c++) begin : g_core
    assign all_lines[c] = gather(route_q[c], src_in);
    // internal numbers simply fall out of the mask [R2] [R3] [R9]
    // nmi line gated while the block input is high [R11]
    assign raw_lines[c] = all_lines[c] & DCR_ROUTABLE
                          & ~(nmi_blk[c] ? (32'h0000_0001 << DCR_NMI_LINE) : 32'h0000_0000);
    // edge lines give one pulse per rising edge, the rest pass the level [R4]
    assign line_d[c]    = (raw_lines[c] & ~DCR_EDGE_LINES)
                          | (raw_lines[c] & ~raw_prev_q[c] & DCR_EDGE_LINES);
    assign nmi_hit[c]   = nmi_blk[c] & all_lines[c][DCR_NMI_LINE];
    assign dropped[c]   = |(all_lines[c] & ~DCR_ROUTABLE);
  end

  // one register stage between source and core [R15] [R1]
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_core_line_q  <= 32'h0000_0000;
      second_core_line_q <= 32'h0000_0000;
      raw_prev_q         <= '0;
    end else begin
      first_core_line_q  <= line_d[0];
      second_core_line_q <= line_d[1];
      raw_prev_q         <= raw_lines;
    end
  end

  // ----------------------------------------------------------------
  // source state words
  // ----------------------------------------------------------------
  // status is a plain view of the inputs, reading cannot touch them [R12]
  logic [95:0] src_pad;
  assign src_pad = 96'(src_in);                       // word s/32, bit s%32 [R13]

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  logic aw_hs;
  logic w_hs;
  logic do_wr;
  logic aw_held_d;
  logic w_held_d;
  logic bvalid_d;
  logic wr_route;
  logic wr_mask;
  logic wr_core;
  logic [6:0] wr_idx;

  assign aw_hs     = s_axi_awvalid & s_axi_awready;
  assign w_hs      = s_axi_wvalid & s_axi_wready;
  assign do_wr     = aw_held_q & w_held_q;            // both halves in, either order
  assign aw_held_d = (aw_held_q | aw_hs) & ~do_wr;
  assign w_held_d  = (w_held_q | w_hs) & ~do_wr;
  assign bvalid_d  = do_wr | (s_axi_bvalid & ~s_axi_bready);
  assign wr_route  = route_hit(aw_addr_q);
  assign wr_mask   = aw_addr_q == ADDR_W'(DCR_MASK_OFS);
  assign wr_core   = aw_addr_q[9];                    // 0x200 half is second core
  assign wr_idx    = aw_addr_q[8:2];

  // handshake and response flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= DCR_RESP_OKAY;
    end else begin
      aw_held_q     <= aw_held_d;
      w_held_q      <= w_held_d;
      // one write in flight: no new halves until the response is taken
      s_axi_awready <= ~aw_held_d & ~bvalid_d;
      s_axi_wready  <= ~w_held_d & ~bvalid_d;
      s_axi_bvalid  <= bvalid_d;
      if (do_wr) begin
        s_axi_bresp <= (wr_route | wr_mask) ? DCR_RESP_OKAY : DCR_RESP_SLVERR;
      end
    end
  end

  // captured payloads, no reset needed on data but kept defined
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_addr_q <= '0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (aw_hs) aw_addr_q <= s_axi_awaddr;
      if (w_hs) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
    end
  end

  // route fields live in byte lane 0; any 5-bit value is legal [R14] [R6]
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      route_q <= {2*NUM_SRC{DCR_ROUTE_RST}};
      mask_q  <= DCR_MASK_RST;
    end else if (do_wr) begin
      if (wr_route && w_strb_q[0]) route_q[wr_core][wr_idx] <= w_data_q[4:0];
      if (wr_mask && w_strb_q[0]) mask_q <= w_data_q[DCR_EVT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  logic              ar_hs;
  logic              rvalid_d;
  logic [31:0]       rd_word;
  logic              rd_ok;
  logic [ADDR_W-1:0] ra;
  logic              rd_evt;

  assign ar_hs    = s_axi_arvalid & s_axi_arready;
  assign rvalid_d = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  assign ra       = s_axi_araddr;
  assign rd_evt   = ra == ADDR_W'(DCR_EVT_OFS);

  // read mux; route reads return the field in the low bits
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (route_hit(ra)) begin
      rd_word = 32'(route_q[ra[9]][ra[8:2]]);
    end else if (ra[ADDR_W-1:4] == DCR_STATE0_BASE[ADDR_W-1:4] && ra[3:2] != 2'h3 && ra[1:0] == 2'h0) begin
      rd_word = src_pad[32*ra[3:2] +: 32];            // [R12] [R13]
    end else if (ra[ADDR_W-1:4] == DCR_STATE1_BASE[ADDR_W-1:4] && ra[3:2] != 2'h3 && ra[1:0] == 2'h0) begin
      rd_word = src_pad[32*ra[3:2] +: 32];            // same sources seen by second core
    end else if (rd_evt) begin
      rd_word = 32'(evt_q);
    end else if (ra == ADDR_W'(DCR_MASK_OFS)) begin
      rd_word = 32'(mask_q);
    end else if (ra == ADDR_W'(DCR_LVL0_OFS)) begin
      rd_word = 32'(top_level(first_core_line_q));    // [R5]
    end else if (ra == ADDR_W'(DCR_LVL1_OFS)) begin
      rd_word = 32'(top_level(second_core_line_q));
    end else begin
      rd_ok   = 1'b0;                                 // unmapped: zero data, slverr
    end
  end

  // read answers one cycle after the address is taken
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= DCR_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid  <= rvalid_d;
      if (ar_hs) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? DCR_RESP_OKAY : DCR_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  logic [DCR_EVT_W-1:0] evt_set;
  logic [DCR_EVT_W-1:0] evt_d;

  assign evt_set[DCR_EVT_NMI0]  = nmi_hit[0];
  assign evt_set[DCR_EVT_NMI1]  = nmi_hit[1];
  assign evt_set[DCR_EVT_DROP0] = dropped[0];
  assign evt_set[DCR_EVT_DROP1] = dropped[1];
  // a set in the clearing cycle survives the read
  assign evt_d = ((ar_hs & rd_evt) ? {DCR_EVT_W{1'b0}} : evt_q) | evt_set;

  // sticky status and level interrupt
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      evt_q <= '0;
      irq_q <= 1'b0;
    end else begin
      evt_q <= evt_d;
      irq_q <= |(evt_d & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_internal_quiet: assert property (@(posedge clk) disable iff (!resetn)
    ((first_core_line_q | second_core_line_q) & ~DCR_ROUTABLE) == 32'h0000_0000) // [R3]
    else $error("internal line driven by a source");

  a_nmi_gate: assert property (@(posedge clk) disable iff (!resetn)
    first_core_nmi_block |=> !first_core_line_q[DCR_NMI_LINE]) // [R11]
    else $error("first core nmi passed while blocked");

  a_route_first: assert property (@(posedge clk) disable iff (!resetn)
    (src_in[64] && route_q[0][64] == 5'h03) |=> first_core_line_q[3]) // [R8]
    else $error("routed source did not reach its line");

  a_route_second: assert property (@(posedge clk) disable iff (!resetn)
    (src_in[53] && route_q[1][53] == 5'h13)
     |=> second_core_line_q[19]) // [R6]
    else $error("second core route not independent");

  a_idle_quiet: assert property (@(posedge clk) disable iff (!resetn)
    (src_in == '0) |=> (first_core_line_q == 32'h0000_0000 && second_core_line_q == 32'h0000_0000)) // [R9]
    else $error("line asserted with no source active");

  a_edge_pulse: assert property (@(posedge clk) disable iff (!resetn)
    first_core_line_q[10] |=> !first_core_line_q[10]) // [R4]
    else $error("edge line held for two cycles");

  a_level_hold: assert property (@(posedge clk) disable iff (!resetn)
    (src_in[3] && route_q[0][3] == 5'h00) [*2] |-> first_core_line_q[0]) // [R4]
    else $error("level line dropped while source high");

  a_state_map: assert property (@(posedge clk) disable iff (!resetn)
    (ar_hs && ra == ADDR_W'(DCR_STATE0_BASE + 12'h004)) |=> s_axi_rdata[21] == $past(src_in[53])) // [R13]
    else $error("state word bit placement wrong");

  a_irq_masked: assert property (@(posedge clk) disable iff (!resetn)
    (mask_q == '0) [*2] |-> !irq_q)
    else $error("interrupt raised while fully masked");

  a_bresp_hold: assert property (@(posedge clk) disable iff (!resetn)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped before taken");

endmodule

`default_nettype wire

// *** dual_core_interrupt_router_tb.sv ***
// self-checking bench for the dual core router
// assumes dcr_pkg and dcr_router are compiled first
`timescale 1ns/1ps
`default_nettype none

module dual_core_interrupt_router_tb;
  import dcr_pkg::*;
  // ----------------------------------------------------------------
  // stimulus, observed outputs and reference model
  // ----------------------------------------------------------------
  logic clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, irq_q, blk0, blk1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, line0, line1;
  logic [3:0]  wstrb = 4'hF;              // full words, except the lane 0 strobe test
  logic [1:0]  bresp, rresp, want_blk = '0, blk_w = '0;
  logic [68:0] want_src = '0, src_w = '0, src;
  int rt0[69], rt1[69];                   // route model per core
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  int seed = 32'h46f29f86;
  logic [31:0] d, r;
  logic [1:0]  rsp;
  int lv_line[6] = '{0, 19, 23, 24, 31, 14};
  int lv_val[6]  = '{1, 2, 3, 4, 5, 7};
  int n0, n1;

  always #2.5 clk = ~clk;                 // 200 MHz

  dcr_far_model u_far (.clk(clk), .resetn(resetn), .want_src(want_src), .want_blk(want_blk),
                       .src_q(src), .blk0_q(blk0), .blk1_q(blk1));
  dcr_router u_dut (.clk(clk), .resetn(resetn), .src_in(src), .first_core_nmi_block(blk0),
    .second_core_nmi_block(blk1), .first_core_line_q(line0), .second_core_line_q(line1), .irq_q(irq_q),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));

  // hang guard: far beyond the roughly 1500 cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // bus master: each channel held until its own ready
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    v  = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // route write, then read back: only the 5-bit field survives
  task automatic route(input int c, input int s, input logic [31:0] v);
    logic [11:0] a;
    a = (c == 0 ? DCR_ROUTE0_BASE : DCR_ROUTE1_BASE) + 12'(4 * s);
    axi_write(a, v, rsp);
    check(32'(rsp), 32'(DCR_RESP_OKAY), "route resp");
    if (c == 0) rt0[s] = int'(v[4:0]);
    else rt1[s] = int'(v[4:0]);
    axi_read(a, r, rsp);
    check(r, {27'h0, v[4:0]}, "route readback");
  endtask

  task automatic settle(input logic [68:0] s, input logic [1:0] b);
    @(posedge clk);
    want_src <= s;
    want_blk <= b;
    src_w = s;
    blk_w = b;
    repeat (4) @(posedge clk);
  endtask

  // steady-state lines: edge lines have long since ended their pulse
  function automatic logic [31:0] exp_lines(input int c);
    logic [31:0] e;
    int ln;
    e = '0;
    for (int s = 0; s < 69; s++) begin
      ln = (c == 0) ? rt0[s] : rt1[s];
      if (src_w[s] && DCR_ROUTABLE[ln]) e[ln] = 1'b1;
    end
    if (blk_w[c]) e[14] = 1'b0;
    return e & ~DCR_EDGE_LINES;
  endfunction

  task automatic compare_all();
    logic [95:0] v;
    v = {27'h0, src_w};
    check(line0, exp_lines(0), "first core lines");
    check(line1, exp_lines(1), "second core lines");
    for (int w = 0; w < 3; w++) begin
      axi_read(DCR_STATE0_BASE + 12'(4 * w), r, rsp);
      check(r, v[32*w +: 32], "first core state");
      axi_read(DCR_STATE1_BASE + 12'(4 * w), r, rsp);
      check(r, v[32*w +: 32], "second core state");
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    for (int s = 0; s < 69; s++) begin
      rt0[s] = 16;
      rt1[s] = 16;
    end
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    axi_read(DCR_ROUTE0_BASE + 12'd272, r, rsp);
    check(r, 32'(DCR_ROUTE_RST), "route reset");
    settle('1, 2'b00);
    compare_all();                               // all parked at reset
    // random routes, random values in upper bits, random sources
    for (int i = 0; i < 40; i++) begin
      d = $random(seed);
      route(i % 2, $unsigned($random(seed)) % 69, d);
      settle(69'({$random(seed), $random(seed), $random(seed)}), 2'($random(seed)));
      compare_all();
    end
    // shared line: two sources on one line, each alone
    route(0, 53, 3);
    route(0, 64, 3);
    route(1, 53, 19);                            // same source, other line on second core
    settle(69'(1) << 53, 2'b00);
    check(32'(line0[3]), 1, "or 53");
    check(32'(line1[19]), 1, "indep 53");
    settle(69'(1) << 64, 2'b00);
    check(32'(line0[3]), 1, "or 64");
    // edge lines give one pulse per rise
    route(0, 0, 10);
    route(1, 0, 22);
    settle('0, 2'b00);
    n0 = 0;
    n1 = 0;
    want_src <= 69'h1;
    repeat (8) begin
      @(posedge clk);
      n0 += int'(line0[10]);
      n1 += int'(line1[22]);
    end
    check(32'(n0), 1, "edge pulse 10");
    check(32'(n1), 1, "edge pulse 22");
    // priority level of the highest pending line
    for (int i = 0; i < 6; i++) begin
      route(0, 3, lv_line[i]);
      settle(69'h8, 2'b00);
      axi_read(DCR_LVL0_OFS, r, rsp);
      check(r, 32'(lv_val[i]), "level");
    end
    route(0, 3, 16);
    // events, mask and interrupt output
    route(0, 2, 6);
    route(1, 2, 17);
    axi_write(DCR_MASK_OFS, 32'hF, rsp);
    settle('0, 2'b00);
    axi_read(DCR_EVT_OFS, r, rsp);
    settle(69'h4, 2'b00);
    settle('0, 2'b00);
    check(32'(irq_q), 1, "irq set");
    axi_write(DCR_MASK_OFS, 32'h0, rsp);
    repeat (3) @(posedge clk);
    check(32'(irq_q), 0, "irq masked");
    axi_write(DCR_MASK_OFS, 32'hF, rsp);
    repeat (3) @(posedge clk);
    check(32'(irq_q), 1, "irq unmasked");
    axi_read(DCR_EVT_OFS, r, rsp);
    check(r, 32'h4, "parked event");
    repeat (3) @(posedge clk);
    check(32'(irq_q), 0, "irq cleared");
    // nmi block holds line 14 on one core only
    route(0, 1, 14);
    route(1, 1, 14);
    settle(69'h2, 2'b01);
    compare_all();
    axi_read(DCR_EVT_OFS, r, rsp);
    check(r, 32'h1, "nmi event");
    settle(69'h2, 2'b00);
    compare_all();
    // unmapped and misaligned places
    axi_read(12'h40C, r, rsp);
    check(r, 32'h0, "hole data");
    check(32'(rsp), 32'(DCR_RESP_SLVERR), "hole read");
    axi_write(12'h41C, 32'h1, rsp);
    check(32'(rsp), 32'(DCR_RESP_SLVERR), "hole write");
    axi_write(12'h002, 32'h1, rsp);
    check(32'(rsp), 32'(DCR_RESP_SLVERR), "misaligned");
    // lane 0 strobe off: route field must keep its value
    wstrb <= 4'hE;
    axi_write(DCR_ROUTE0_BASE + 12'h014, 32'h1, rsp);
    wstrb <= 4'hF;
    axi_read(DCR_ROUTE0_BASE + 12'h014, r, rsp);
    check(r, 32'(rt0[5]), "lane 0 off");
    finish_test();
  end
endmodule

`default_nettype wire
